// File: logic/quasi_bidir_port_set.sv
`default_nettype none
module quasi_bidir_port_set
  import qport_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire latchWr_t latchWr,
  input wire addrMode_t addrMode,
  input wire busReq_t busReq,
  input wire altOut_t altOut,
  input wire logic [PORT_W-1:0] pinIn1,
  input wire logic [PORT_W-1:0] pinIn2,
  input wire logic [PORT_W-1:0] pinIn3,
  output pinDrv_t drv1,
  output pinDrv_t drv2,
  output pinDrv_t drv3,
  output logic [PORT_W-1:0] portLevel1,
  output logic [PORT_W-1:0] portLevel2,
  output logic [PORT_W-1:0] portLevel3,
  output altIn_t altIn
);
  logic rstMeta_r;
  logic rstSyncN;
  logic [PORT_W-1:0] latch1_r;
  logic [PORT_W-1:0] latch2_r;
  logic [PORT_W-1:0] latch3_r;
  logic [PORT_W-1:0] lvl1_r;
  logic [PORT_W-1:0] lvl2_r;
  logic [PORT_W-1:0] lvl3_r;
  logic [PORT_W-1:0] lvl1Prev_r;
  busState_t busState_r;
  busState_t busState_nxt;
  logic [PORT_W-1:0] p2Val_r;
  logic p2Hold_r;
  logic [PORT_W-1:0] alt1;
  logic [PORT_W-1:0] alt3;

  // write a latch only when this port is selected
  function automatic logic [PORT_W-1:0] nextLatch(
    input logic [PORT_W-1:0] cur,
    input latchWr_t wr,
    input logic [1:0] sel
  );
    return (wr.valid && wr.sel == sel) ? wr.data : cur;
  endfunction : nextLatch

  // pin wants low if latch or its alternate output is low
  function automatic logic [PORT_W-1:0] quasiWant(
    input logic [PORT_W-1:0] latchVal,
    input logic [PORT_W-1:0] altVal
  );
    return latchVal & altVal;
  endfunction : quasiWant

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN <= rstMeta_r;
    end
  end

  // port latches, all ones out of reset
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      latch1_r <= LATCH_RST;
      latch2_r <= LATCH_RST;
      latch3_r <= LATCH_RST;
    end else begin
      latch1_r <= nextLatch(latch1_r, latchWr, SEL_P1);
      latch2_r <= nextLatch(latch2_r, latchWr, SEL_P2);
      latch3_r <= nextLatch(latch3_r, latchWr, SEL_P3);
    end
  end

  // alternate outputs; unused positions stay high
  always_comb begin
    alt1 = ALL_ONES;
    alt1[P1_T2IO] = altOut.timer2ExtIo;
    alt1[P1_S1TX] = altOut.serial1Tx;
    alt3 = ALL_ONES;
    alt3[P3_S0TX] = altOut.serial0Tx;
    alt3[P3_WRS] = altOut.wrStrobeN;
    alt3[P3_RDS] = altOut.rdStrobeN;
  end

  // pin levels sampled for reads and alternate inputs
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lvl1_r <= LATCH_RST;
      lvl2_r <= LATCH_RST;
      lvl3_r <= LATCH_RST;
      lvl1Prev_r <= LATCH_RST;
    end else begin
      lvl1_r <= pinIn1;
      lvl2_r <= pinIn2;
      lvl3_r <= pinIn3;
      lvl1Prev_r <= lvl1_r;
    end
  end

  assign portLevel1 = lvl1_r;
  assign portLevel2 = lvl2_r;
  assign portLevel3 = lvl3_r;

  // alternate inputs, edge pulses for port 1 upper nibble
  always_comb begin
    altIn.timer2ExtIo = lvl1_r[P1_T2IO];
    altIn.timer2CaptureTrigger = lvl1_r[P1_T2TRIG];
    altIn.serial1Rx = lvl1_r[P1_S1RX];
    altIn.extIrqTwoRise = lvl1_r[P1_IRQ2] & ~lvl1Prev_r[P1_IRQ2];
    altIn.extIrqThreeFall = ~lvl1_r[P1_IRQ3] & lvl1Prev_r[P1_IRQ3];
    altIn.extIrqFourRise = lvl1_r[P1_IRQ4] & ~lvl1Prev_r[P1_IRQ4];
    altIn.extIrqFiveFall = ~lvl1_r[P1_IRQ5] & lvl1Prev_r[P1_IRQ5];
    altIn.serial0Rx = lvl3_r[P3_S0RX];
    altIn.extIrqZero = lvl3_r[P3_IRQ0];
    altIn.extIrqOne = lvl3_r[P3_IRQ1];
    altIn.timer0CountIn = lvl3_r[P3_T0IN];
    altIn.timer1CountIn = lvl3_r[P3_T1IN];
  end

  // external bus phase tracker for port 2
  always_comb begin
    case (busState_r)
      BUS_IDLE, BUS_FIRST, BUS_SECOND: begin
        if (!busReq.active) begin
          busState_nxt = BUS_IDLE;
        end else if (busReq.secondPhase) begin
          busState_nxt = BUS_SECOND;
        end else begin
          busState_nxt = BUS_FIRST;
        end
      end
      default: busState_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      busState_r <= BUS_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  // port 2 value: latch when idle, all ones on a page 2 read, bus bytes otherwise
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      p2Val_r <= LATCH_RST;
      p2Hold_r <= 1'b0;
    end else begin
      case (busState_nxt)
        BUS_FIRST: begin
          p2Val_r <= busReq.addrHi;
          p2Hold_r <= 1'b1;
        end
        BUS_SECOND: begin
          case (addrMode)
            ADDR_PAGE1: begin
              p2Val_r <= busReq.addrLo;
              p2Hold_r <= 1'b1;
            end
            ADDR_PAGE2: begin
              // read data phase releases port to weak high
              p2Val_r <= busReq.write ? busReq.wrData : ALL_ONES;
              p2Hold_r <= busReq.write;
            end
            default: begin
              p2Val_r <= busReq.addrHi;
              p2Hold_r <= 1'b1;
            end
          endcase
        end
        default: begin
          p2Val_r <= nextLatch(latch2_r, latchWr, SEL_P2);
          p2Hold_r <= 1'b0;
        end
      endcase
    end
  end

  // one drive cell per port
  quasi_pin_cell u_cell1 (
    .clk_sys(clk_sys),
    .rstN(rstSyncN),
    .want(quasiWant(latch1_r, alt1)),
    .hold(1'b0),
    .drv(drv1)
  );

  quasi_pin_cell u_cell2 (
    .clk_sys(clk_sys),
    .rstN(rstSyncN),
    .want(p2Val_r),
    .hold(p2Hold_r),
    .drv(drv2)
  );

  quasi_pin_cell u_cell3 (
    .clk_sys(clk_sys),
    .rstN(rstSyncN),
    .want(quasiWant(latch3_r, alt3)),
    .hold(1'b0),
    .drv(drv3)
  );

  property p_reset_high;
    @(posedge clk_sys)
    (rstSyncN && !$past(rstSyncN)) |->
      (latch1_r == LATCH_RST && latch3_r == LATCH_RST
       && drv1.oeN == ALL_ONES && drv2.weakUp == ALL_ONES);
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("ports not weak high after reset");

  property p_zero_pulls_down;
    @(posedge clk_sys) disable iff (!rstSyncN)
    $past(rstSyncN) |->
      ((~$past(latch1_r) & (drv1.oeN | drv1.out)) == 8'h00);
  endproperty
  a_zero_pulls_down: assert property (p_zero_pulls_down)
    else $error("latched 0 not pulled down");

  property p_read_pin;
    @(posedge clk_sys) disable iff (!rstSyncN)
    $past(rstSyncN) |-> (portLevel3 == $past(pinIn3));
  endproperty
  a_read_pin: assert property (p_read_pin)
    else $error("port read is not pin level");

  property p_irq_rise;
    @(posedge clk_sys) disable iff (!rstSyncN)
    ($past(rstSyncN, 2) && $rose(pinIn1[P1_IRQ2])) |=>
      (altIn.extIrqTwoRise ##1 !altIn.extIrqTwoRise);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("rising edge interrupt pulse wrong");

  property p_irq_fall;
    @(posedge clk_sys) disable iff (!rstSyncN)
    ($past(rstSyncN, 2) && $fell(pinIn1[P1_IRQ3])) |=>
      altIn.extIrqThreeFall;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("falling edge interrupt missed");

  sequence s_first_phase;
    busReq.active && !busReq.secondPhase;
  endsequence

  property p_addr_high;
    @(posedge clk_sys) disable iff (!rstSyncN)
    s_first_phase |-> ##2
      (drv2.out == $past(busReq.addrHi, 2) && drv2.oeN == 8'h00);
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("port 2 not driving high address");

  property p_page1_low;
    @(posedge clk_sys) disable iff (!rstSyncN)
    (busReq.active && busReq.secondPhase && addrMode == ADDR_PAGE1)
      |-> ##2 (drv2.out == $past(busReq.addrLo, 2) && drv2.oeN == 8'h00);
  endproperty
  a_page1_low: assert property (p_page1_low)
    else $error("page mode 1 low address missing");

  property p_page2_data;
    @(posedge clk_sys) disable iff (!rstSyncN)
    (busReq.active && busReq.secondPhase && busReq.write
     && addrMode == ADDR_PAGE2)
      |-> ##2 (drv2.out == $past(busReq.wrData, 2) && drv2.oeN == 8'h00);
  endproperty
  a_page2_data: assert property (p_page2_data)
    else $error("page mode 2 data missing");

  property p_strobe_gate;
    @(posedge clk_sys) disable iff (!rstSyncN)
    (!altOut.wrStrobeN && $past(rstSyncN)) |-> ##1
      (!drv3.out[P3_WRS] && !drv3.oeN[P3_WRS]);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate)
    else $error("write strobe did not reach pin");
endmodule : quasi_bidir_port_set
`default_nettype wire

// File: inc/qport_pkg.sv
`default_nettype none
package qport_pkg;
  localparam int PORT_W = 8;
  localparam int CLK_NS = 8;
  // brief strong pull-up after a 0 to 1 write, least time in ns
  localparam int STRONG_UP_NS = 20;
  localparam int STRONG_UP_CYC_I = (STRONG_UP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] STRONG_UP_CYC = CNT_W'(STRONG_UP_CYC_I);
  localparam logic [PORT_W-1:0] LATCH_RST = 8'hff;
  localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;
  // port select codes on the latch write port
  localparam logic [1:0] SEL_P1 = 2'h0;
  localparam logic [1:0] SEL_P2 = 2'h1;
  localparam logic [1:0] SEL_P3 = 2'h2;
  // port 1 alternate bit positions
  localparam int P1_T2IO = 0;
  localparam int P1_T2TRIG = 1;
  localparam int P1_S1RX = 2;
  localparam int P1_S1TX = 3;
  localparam int P1_IRQ2 = 4;
  localparam int P1_IRQ3 = 5;
  localparam int P1_IRQ4 = 6;
  localparam int P1_IRQ5 = 7;
  // port 3 alternate bit positions
  localparam int P3_S0RX = 0;
  localparam int P3_S0TX = 1;
  localparam int P3_IRQ0 = 2;
  localparam int P3_IRQ1 = 3;
  localparam int P3_T0IN = 4;
  localparam int P3_T1IN = 5;
  localparam int P3_WRS = 6;
  localparam int P3_RDS = 7;

  typedef enum logic [1:0] {
    ADDR_PLAIN = 2'b00,
    ADDR_PAGE1 = 2'b01,
    ADDR_PAGE2 = 2'b11
  } addrMode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_FIRST = 2'b01,
    BUS_SECOND = 2'b11
  } busState_t;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic [PORT_W-1:0] data;
  } latchWr_t;

  typedef struct packed {
    logic active;
    logic secondPhase;
    logic write;
    logic [PORT_W-1:0] addrHi;
    logic [PORT_W-1:0] addrLo;
    logic [PORT_W-1:0] wrData;
  } busReq_t;

  typedef struct packed {
    logic timer2ExtIo;
    logic serial1Tx;
    logic serial0Tx;
    logic wrStrobeN;
    logic rdStrobeN;
  } altOut_t;

  typedef struct packed {
    logic timer2ExtIo;
    logic timer2CaptureTrigger;
    logic serial1Rx;
    logic extIrqTwoRise;
    logic extIrqThreeFall;
    logic extIrqFourRise;
    logic extIrqFiveFall;
    logic serial0Rx;
    logic extIrqZero;
    logic extIrqOne;
    logic timer0CountIn;
    logic timer1CountIn;
  } altIn_t;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oeN;
    logic [PORT_W-1:0] weakUp;
  } pinDrv_t;
endpackage : qport_pkg
`default_nettype wire

// File: logic/quasi_pin_cell.sv
`default_nettype none
module quasi_pin_cell
  import qport_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic [PORT_W-1:0] want,
  input wire logic hold,
  output pinDrv_t drv
);
  logic [PORT_W-1:0] wantReg_r;
  logic holdReg_r;
  logic [CNT_W-1:0] cnt_r [PORT_W];
  logic [PORT_W-1:0] rise;

  assign rise = want & ~wantReg_r;

  // wanted level per pin, high out of reset
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wantReg_r <= LATCH_RST;
      holdReg_r <= 1'b0;
    end else begin
      wantReg_r <= want;
      holdReg_r <= hold;
    end
  end

  // strong pull-up timers, loaded on each 0 to 1 change
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < PORT_W; i++) cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (rise[i]) begin
          cnt_r[i] <= STRONG_UP_CYC;
        end else if (cnt_r[i] != '0) begin
          cnt_r[i] <= cnt_r[i] - 1'b1;
        end
      end
    end
  end

  // low: strong pulldown; high: strong briefly, then weak only unless hold keeps it strong
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      drv.out[i] = wantReg_r[i];
      drv.weakUp[i] = wantReg_r[i];
      drv.oeN[i] = wantReg_r[i] & (cnt_r[i] == '0) & ~holdReg_r;
    end
  end

  sequence s_rise0;
    !wantReg_r[0] ##1 wantReg_r[0];
  endsequence

  property p_strong_up;
    @(posedge clk_sys) disable iff (!rstN)
    s_rise0 |-> (!drv.oeN[0] && drv.out[0]);
  endproperty
  a_strong_up: assert property (p_strong_up)
    else $error("no strong pull-up after 0 to 1");

  property p_weak_after;
    @(posedge clk_sys) disable iff (!rstN)
    (!wantReg_r[0] ##1 (wantReg_r[0] && !holdReg_r) [*4]) |-> drv.oeN[0];
  endproperty
  a_weak_after: assert property (p_weak_after)
    else $error("strong pull-up did not end");

  property p_low_held;
    @(posedge clk_sys) disable iff (!rstN)
    !wantReg_r[0] |-> (!drv.oeN[0] && !drv.out[0] && !drv.weakUp[0]);
  endproperty
  a_low_held: assert property (p_low_held)
    else $error("pin at 0 not strongly pulled down");
endmodule : quasi_pin_cell
`default_nettype wire

// File: dv/port_far_side.sv
`default_nettype none
module port_far_side
  import qport_pkg::*;
(
  input wire logic clk_sys,
  input wire pinDrv_t drv,
  input wire logic [PORT_W-1:0] extEn,
  input wire logic [PORT_W-1:0] extVal,
  output logic [PORT_W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r;
  // changing pattern stands in for a floating wire
  initial flip_r = 1'b0;
  always @(posedge clk_sys) begin
    flip_r <= ~flip_r;
  end
  // strong drive wins, else outside circuit overrides the weak pullup
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!drv.oeN[i]) begin
        pin[i] = drv.out[i];
      end else if (extEn[i]) begin
        pin[i] = extVal[i];
      end else if (drv.weakUp[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flip_r;
      end
    end
  end
endmodule : port_far_side
`default_nettype wire

// File: dv/quasi_bidir_port_set_tb.sv
`default_nettype none
module quasi_bidir_port_set_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import qport_pkg::*;
  logic clk_sys;
  logic nrst;
  latchWr_t latchWr;
  addrMode_t addrMode;
  busReq_t busReq;
  altOut_t altOut;
  logic [PORT_W-1:0] en1, en2, en3, val1, val2, val3;
  logic [PORT_W-1:0] pin1, pin2, pin3, lvl1, lvl2, lvl3;
  pinDrv_t drv1, drv2, drv3;
  altIn_t altIn;
  logic [31:0] seed;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int altPort[5] = '{3, 3, 3, 1, 1};
  int altBit[5] = '{7, 6, 1, 3, 0};

  quasi_bidir_port_set dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .latchWr(latchWr), .addrMode(addrMode), .busReq(busReq),
    .altOut(altOut), .pinIn1(pin1), .pinIn2(pin2), .pinIn3(pin3),
    .drv1(drv1), .drv2(drv2), .drv3(drv3), .portLevel1(lvl1),
    .portLevel2(lvl2), .portLevel3(lvl3), .altIn(altIn));
  port_far_side far1_u (.clk_sys(clk_sys), .drv(drv1), .extEn(en1),
    .extVal(val1), .pin(pin1));
  port_far_side far2_u (.clk_sys(clk_sys), .drv(drv2), .extEn(en2),
    .extVal(val2), .pin(pin2));
  port_far_side far3_u (.clk_sys(clk_sys), .drv(drv3), .extEn(en3),
    .extVal(val3), .pin(pin3));

  // clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  function automatic logic [7:0] r8();
    repeat (8) seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : '0);
    return seed[15:8];
  endfunction : r8
  function automatic logic [7:0] exp_pin(input logic [7:0] e, v);
    return ~e | v;
  endfunction : exp_pin
  function automatic logic [7:0] alt_exp(input logic [7:0] p1, p3);
    return {p1[0], p1[1], p1[2], p3[0], p3[2], p3[3], p3[4], p3[5]};
  endfunction : alt_exp
  function automatic logic [7:0] alt_seen();
    return {altIn.timer2ExtIo, altIn.timer2CaptureTrigger,
      altIn.serial1Rx, altIn.serial0Rx, altIn.extIrqZero,
      altIn.extIrqOne, altIn.timer0CountIn, altIn.timer1CountIn};
  endfunction : alt_seen
  function automatic logic irq_of(input int b);
    case (b)
      4: return altIn.extIrqTwoRise;
      5: return altIn.extIrqThreeFall;
      6: return altIn.extIrqFourRise;
      default: return altIn.extIrqFiveFall;
    endcase
  endfunction : irq_of

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // driven level, enable, and weak pullup wherever not driven
  task automatic chk_drv(input int p, input logic [7:0] o, e);
    pinDrv_t d;
    d = (p == 1) ? drv1 : ((p == 2) ? drv2 : drv3);
    chk($sformatf("drv%0d.out", p), d.out | d.oeN, o | e);
    chk($sformatf("drv%0d.oeN", p), d.oeN, e);
    chk($sformatf("drv%0d.weakUp", p), d.weakUp | ~d.oeN, 8'hff);
  endtask : chk_drv
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    cyc(1);
    latchWr <= '{valid: 1'b1, sel: sel, data: d};
    cyc(1);
    latchWr.valid <= 1'b0;
  endtask : wr
  task automatic do_reset();
    nrst <= 1'b0;
    cyc(10);
    nrst <= 1'b1;
    cyc(3);
  endtask : do_reset
  task automatic pulses(input int b, input logic v, output int n);
    cyc(1);
    en1[b] <= 1'b1;
    val1[b] <= v;
    n = 0;
    repeat (5) begin
      cyc(1);
      #1 if (irq_of(b) === 1'b1) n++;
    end
  endtask : pulses
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    logic [7:0] a, b, c, d, m;
    int n;
    nrst = 1'b0;
    latchWr = '0;
    addrMode = ADDR_PLAIN;
    busReq = '0;
    altOut = '1;
    {en1, en2, en3, val1, val2, val3} = '0;
    seed = 32'hadd5b101;
    do_reset();
    // reset leaves every port weakly high
    #1 for (int p = 1; p <= 3; p++) chk_drv(p, 8'hff, 8'hff);
    chk("level", lvl1 & lvl2 & lvl3, 8'hff);
    // random latch byte, then all ones with a brief strong pull-up
    for (int p = 0; p < 3; p++) begin
      d = r8() & 8'hfe;
      wr(2'(p), d);
      #1 chk_drv(p + 1, 8'hff, 8'hff);
      cyc(1);
      #1 chk_drv(p + 1, d, d);
      wr(2'(p), 8'hff);
      #1 chk_drv(p + 1, d, d);
      repeat (3) begin
        cyc(1);
        #1 chk_drv(p + 1, 8'hff, d);
      end
      cyc(1);
      #1 chk_drv(p + 1, 8'hff, 8'hff);
    end
    // random outside drive read back through levels and alternates
    repeat (12) begin
      cyc(1);
      en1 <= r8();
      en2 <= r8();
      en3 <= r8();
      val1 <= r8();
      val2 <= r8();
      val3 <= r8();
      cyc(2);
      #1 chk("lvl1", lvl1, exp_pin(en1, val1));
      chk("lvl2", lvl2, exp_pin(en2, val2));
      chk("lvl3", lvl3, exp_pin(en3, val3));
      a = alt_exp(exp_pin(en1, val1), exp_pin(en3, val3));
      chk("altIn", alt_seen(), a);
    end
    cyc(1);
    {en1, en2, en3} <= '0;
    val1 <= 8'hff;
    // each interrupt pin taken low, then high again
    for (int k = 4; k < 8; k++) begin
      pulses(k, 1'b0, n);
      chk("fallPulse", 8'(n), (k % 2) ? 8'h01 : 8'h00);
      pulses(k, 1'b1, n);
      chk("risePulse", 8'(n), (k % 2) ? 8'h00 : 8'h01);
    end
    // each alternate output low, then held low by a cleared latch
    for (int i = 0; i < 5; i++) begin
      m = ~(8'h01 << altBit[i]);
      cyc(1);
      altOut <= altOut_t'(~(5'h01 << i));
      cyc(2);
      #1 chk_drv(altPort[i], m, m);
      cyc(1);
      altOut <= '1;
      wr(altPort[i] == 1 ? SEL_P1 : SEL_P3, m);
      cyc(5);
      #1 chk_drv(altPort[i], m, m);
      wr(altPort[i] == 1 ? SEL_P1 : SEL_P3, 8'hff);
      cyc(6);
    end
    // bus cycles: plain, page 1, page 2 write, page 2 read
    for (int k = 0; k < 4; k++) begin
      a = r8();
      b = r8();
      c = r8();
      d = r8();
      cyc(1);
      addrMode <= (k == 0) ? ADDR_PLAIN : ((k == 1) ? ADDR_PAGE1 : ADDR_PAGE2);
      busReq <= '{active: 1'b1, secondPhase: 1'b0, write: (k != 3),
        addrHi: a, addrLo: b, wrData: c};
      cyc(2);
      #1 chk_drv(2, a, 8'h00);
      cyc(1);
      busReq.secondPhase <= 1'b1;
      en2 <= (k == 3) ? 8'hff : 8'h00;
      val2 <= d;
      // wait out the strong pull-up on a read release, then one sample
      cyc(6);
      m = (k == 0) ? a : ((k == 1) ? b : c);
      if (k == 3) m = 8'hff;
      #1 chk_drv(2, m, (k == 3) ? 8'hff : 8'h00);
      if (k == 3) chk("busRead", lvl2, d);
      cyc(1);
      busReq <= '0;
      en2 <= '0;
      cyc(6);
      #1 chk_drv(2, 8'hff, 8'hff);
    end
    // reset in mid-run clears a low latch
    wr(SEL_P1, 8'h00);
    cyc(2);
    #1 chk_drv(1, 8'h00, 8'h00);
    do_reset();
    #1 chk_drv(1, 8'hff, 8'hff);
    wrap_up();
  end
endmodule : quasi_bidir_port_set_tb
`default_nettype wire
